// ==== twrg_top.sv ====
// terminal supervision: awake input, watchdog, outgoing reset pulse
//
// The register offsets and strobed register access are this design's own decisions.
`default_nettype none
module twrg_top #(
    parameter int unsigned WDOG_CYCLES = twrg_pkg::WDOG_CYC,
    parameter int unsigned PULSE_CYCLES = twrg_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire twrg_pkg::twrg_bus_t bus_i,
    output logic [7:0] rdata_o,
    // pins and layer-1 status
    input wire logic mode_pin_one_i,
    input wire logic serial_clk_active_i,
    input wire logic [3:0] ci_code_i,
    input wire logic serial_upstream_line_i,
    output logic serial_upstream_line_o,
    input wire logic board_clear_pulse_pin_i,
    output logic board_clear_pulse_pin_o,
    output logic board_clear_pulse_pin_oe_o
);
    logic tfe_r;
    logic rss_r;
    logic rss_d_r;
    logic saw_r;
    logic wov_r;
    logic cic_r;
    logic [2:0] eaw_sync_r;
    logic eaw_stable_r;
    logic [2:0] clk_sync_r;
    logic clk_stable_r;
    logic [3:0] ci_prev_r;
    logic force_du_r;
    logic [twrg_pkg::CNT_W-1:0] wdog_r;
    logic [twrg_pkg::CNT_W-1:0] pulse_r;
    logic pulse_on_r;
    twrg_pkg::twrg_key_t key_r;
    logic [7:0] rdata_r;
    logic eaw_fall;
    logic clk_rise;
    logic ci_change;
    logic wdog_expire;
    logic key_wr;
    logic key_ok;
    logic trig;
    logic [7:0] wdata;

    function automatic logic hit(input twrg_pkg::twrg_bus_t b, input logic [3:0] a);
        hit = b.wr && (b.addr == a);
    endfunction

    assign wdata = bus_i.wdata;
    assign key_wr = hit(bus_i, twrg_pkg::ADDR_KEY);

    // pin inputs: change accepted once stages two and three agree
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            eaw_sync_r <= 3'h7;
            eaw_stable_r <= 1'b1;
            clk_sync_r <= 3'h0;
            clk_stable_r <= 1'b0;
        end else begin
            eaw_sync_r <= {eaw_sync_r[1:0], mode_pin_one_i};
            clk_sync_r <= {clk_sync_r[1:0], serial_clk_active_i};
            if (eaw_sync_r[1] == eaw_sync_r[2]) begin
                eaw_stable_r <= eaw_sync_r[2];
            end
            if (clk_sync_r[1] == clk_sync_r[2]) begin
                clk_stable_r <= clk_sync_r[2];
            end
        end
    end

    // the awake pin only means something once enabled
    assign eaw_fall = tfe_r && (eaw_sync_r[1] == eaw_sync_r[2]) && !eaw_sync_r[2]
        && eaw_stable_r;
    assign clk_rise = (clk_sync_r[1] == clk_sync_r[2]) && clk_sync_r[2] && !clk_stable_r;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ci_prev_r <= 4'h0;
        end else begin
            ci_prev_r <= ci_code_i;
        end
    end
    assign ci_change = tfe_r && (ci_prev_r != ci_code_i);

    // control register: enable is one-way
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tfe_r <= twrg_pkg::RST_CTRL[twrg_pkg::CTRL_TFE_BIT];
            rss_r <= twrg_pkg::RST_CTRL[twrg_pkg::CTRL_RSS_BIT];
            rss_d_r <= twrg_pkg::RST_CTRL[twrg_pkg::CTRL_RSS_BIT];
        end else begin
            rss_d_r <= rss_r;
            if (hit(bus_i, twrg_pkg::ADDR_CTRL)) begin
                tfe_r <= tfe_r | wdata[twrg_pkg::CTRL_TFE_BIT];
                rss_r <= wdata[twrg_pkg::CTRL_RSS_BIT];
            end
        end
    end

    // key sequence tracker
    assign key_ok = key_wr && (key_r == twrg_pkg::TWRG_KEY_HALF)
        && !wdata[twrg_pkg::KEY_FIRST_BIT] && wdata[twrg_pkg::KEY_SECOND_BIT];
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            key_r <= twrg_pkg::TWRG_KEY_IDLE;
        end else if (key_wr) begin
            if (wdata[twrg_pkg::KEY_FIRST_BIT] && !wdata[twrg_pkg::KEY_SECOND_BIT]) begin
                key_r <= twrg_pkg::TWRG_KEY_HALF;
            end else begin
                key_r <= twrg_pkg::TWRG_KEY_IDLE;
            end
        end
    end

    // watchdog: counts only while enabled and the serial clocks run
    assign wdog_expire = tfe_r && clk_stable_r
        && (wdog_r == twrg_pkg::CNT_W'(WDOG_CYCLES - 1));
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wdog_r <= '0;
        end else if (!tfe_r || key_ok || (rss_r != rss_d_r) || wdog_expire) begin
            wdog_r <= '0;
        end else if (clk_stable_r) begin
            wdog_r <= wdog_r + twrg_pkg::CNT_W'(1);
        end
    end

    // sticky flags, set wins over read-clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            saw_r <= twrg_pkg::RST_STAT[twrg_pkg::ST_SAW_BIT];
            wov_r <= twrg_pkg::RST_STAT[twrg_pkg::ST_WOV_BIT];
            cic_r <= twrg_pkg::RST_STAT[twrg_pkg::ST_CIC_BIT];
        end else begin
            if (eaw_fall) begin
                saw_r <= 1'b1;
            end else if (bus_i.rd && bus_i.addr == twrg_pkg::ADDR_STAT) begin
                saw_r <= 1'b0;
            end
            if (wdog_expire) begin
                wov_r <= 1'b1;
            end else if (bus_i.rd && bus_i.addr == twrg_pkg::ADDR_STAT) begin
                wov_r <= 1'b0;
            end
            if (ci_change) begin
                cic_r <= 1'b1;
            end else if (bus_i.rd && bus_i.addr == twrg_pkg::ADDR_STAT) begin
                cic_r <= 1'b0;
            end
        end
    end

    // upstream line forced low from an awake edge until the clocks start
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            force_du_r <= 1'b0;
        end else if (eaw_fall) begin
            force_du_r <= 1'b1;
        end else if (clk_rise) begin
            force_du_r <= 1'b0;
        end
    end
    assign serial_upstream_line_o = serial_upstream_line_i & ~force_du_r;

    // reset source choice
    assign trig = tfe_r && (rss_r ? wdog_expire
        : (eaw_fall || ci_change || clk_rise));

    // outgoing pulse; it feeds no internal reset
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pulse_on_r <= 1'b0;
            pulse_r <= '0;
        end else if (pulse_on_r) begin
            if (pulse_r == twrg_pkg::CNT_W'(PULSE_CYCLES - 1)) begin
                pulse_on_r <= 1'b0;
            end
            pulse_r <= pulse_r + twrg_pkg::CNT_W'(1);
        end else if (trig) begin
            pulse_on_r <= 1'b1;
            pulse_r <= '0;
        end
    end
    assign board_clear_pulse_pin_o = pulse_on_r;
    assign board_clear_pulse_pin_oe_o = pulse_on_r;

    // read port, data in the following cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 8'h00;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                twrg_pkg::ADDR_CTRL: rdata_r <= {6'h00, rss_r, tfe_r};
                twrg_pkg::ADDR_STAT: rdata_r <= {4'h0, pulse_on_r, cic_r, wov_r, saw_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_o = rdata_r;
    // board_clear_pulse_pin_i is read back only by the far side
    logic unused_pin;
    assign unused_pin = board_clear_pulse_pin_i;
endmodule // twrg_top
`default_nettype wire

// ==== twrg_pkg.sv ====
// package for the terminal watchdog and reset generator
`default_nettype none
package twrg_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned WDOG_MS = 128;
    localparam int unsigned PULSE_MS = 5;
    localparam int unsigned WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;
    localparam int unsigned PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 26;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_KEY = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam int CTRL_TFE_BIT = 0;
    localparam int CTRL_RSS_BIT = 1;
    localparam int KEY_FIRST_BIT = 1;
    localparam int KEY_SECOND_BIT = 0;
    localparam int ST_SAW_BIT = 0;
    localparam int ST_WOV_BIT = 1;
    localparam int ST_CIC_BIT = 2;
    localparam int ST_PULSE_BIT = 3;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    typedef enum logic [1:0] {
        TWRG_KEY_IDLE = 2'b00,
        TWRG_KEY_HALF = 2'b01
    } twrg_key_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } twrg_bus_t;
endpackage
`default_nettype wire

// ==== twrg_top_assertions.sv ====
// port checker for the terminal watchdog and reset generator
`default_nettype none
module twrg_chk #(
    parameter int unsigned WDOG_CYCLES = 64,
    parameter int unsigned PULSE_CYCLES = 16
) (
    // clock, reset and register port
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire twrg_pkg::twrg_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    // pins
    input wire logic mode_pin_one_i,
    input wire logic serial_upstream_line_i,
    input wire logic serial_upstream_line_o,
    input wire logic board_clear_pulse_pin_o,
    input wire logic board_clear_pulse_pin_oe_o
);
    int unsigned hi_r;
    logic tfe_r;
    // enable can only be set, so a plain sticky copy is enough
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i)
            tfe_r <= 1'b0;
        else if (bus_i.wr && bus_i.addr == twrg_pkg::ADDR_CTRL && bus_i.wdata[0])
            tfe_r <= 1'b1;
    end
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i)
            hi_r <= 0;
        else
            hi_r <= board_clear_pulse_pin_o ? hi_r + 1 : 0;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence awake_fall_s;
        $fell(mode_pin_one_i) && tfe_r && serial_upstream_line_i;
    endsequence
    sequence pulse_rd_s;
        bus_i.rd && bus_i.addr == twrg_pkg::ADDR_STAT && board_clear_pulse_pin_o;
    endsequence
    pin_enable_match_a: assert property (
        board_clear_pulse_pin_oe_o == board_clear_pulse_pin_o) else $error("pin enable off");
    pulse_no_extend_a: assert property (hi_r <= PULSE_CYCLES)
        else $error("pulse too long");
    pulse_width_a: assert property (
        $fell(board_clear_pulse_pin_o) |-> hi_r == PULSE_CYCLES) else $error("pulse width");
    pulse_holds_a: assert property ($rose(board_clear_pulse_pin_o) |->
        board_clear_pulse_pin_o [*8]) else $error("pulse cut short");
    quiet_until_enable_a: assert property (!tfe_r |-> !board_clear_pulse_pin_o &&
        serial_upstream_line_o == serial_upstream_line_i) else $error("active while off");
    awake_forces_low_a: assert property (awake_fall_s |-> ##[2:8]
        !serial_upstream_line_o) else $error("upstream not forced");
    status_pulse_bit_a: assert property (pulse_rd_s |=>
        rdata_o[twrg_pkg::ST_PULSE_BIT]) else $error("pulse bit missing");
    key_read_zero_a: assert property (
        $past(bus_i.rd && bus_i.addr == twrg_pkg::ADDR_KEY) |-> rdata_o == 8'h00)
        else $error("key readable");
endmodule // twrg_chk
bind twrg_top twrg_chk #(.WDOG_CYCLES(WDOG_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) twrg_chk_inst (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .mode_pin_one_i(mode_pin_one_i), .serial_upstream_line_i(serial_upstream_line_i),
    .serial_upstream_line_o(serial_upstream_line_o),
    .board_clear_pulse_pin_o(board_clear_pulse_pin_o),
    .board_clear_pulse_pin_oe_o(board_clear_pulse_pin_oe_o));
`default_nettype wire

// ==== twrg_pin_model.sv ====
// board reset line as the host sees it
`default_nettype none
module twrg_pin_model (
    // device side
    input wire logic drive_i,
    input wire logic drive_en_i,
    // resolved line
    output logic pin_o
);
    // released line falls to its pull-down, so no stale level lingers
    assign pin_o = drive_en_i ? drive_i : 1'b0;
endmodule // twrg_pin_model
`default_nettype wire

// ==== twrg_top_tb.sv ====
// self-checking bench for the terminal watchdog and reset generator
`default_nettype none
module twrg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b1;
    logic sact = 1'b0;
    logic [3:0] ci = 4'h0;
    twrg_pkg::twrg_bus_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic up_o;
    logic pin_o;
    logic pin_oe;
    wire logic pin;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    always #2 clk = ~clk;
    twrg_top #(.WDOG_CYCLES(64), .PULSE_CYCLES(16)) twrg_top_inst (.core_clk_i(clk),
        .sys_rst_i(rst), .bus_i(bus), .rdata_o(rdata), .mode_pin_one_i(mode),
        .serial_clk_active_i(sact), .ci_code_i(ci), .serial_upstream_line_i(1'b1),
        .serial_upstream_line_o(up_o), .board_clear_pulse_pin_i(pin),
        .board_clear_pulse_pin_o(pin_o), .board_clear_pulse_pin_oe_o(pin_oe));
    twrg_pin_model twrg_pin_model_inst (.drive_i(pin_o), .drive_en_i(pin_oe), .pin_o(pin));
    task close_out;
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 rv = rdata;
    endtask
    // leaves n at lim when the pin never rises
    task waitp(input int lim);
        n = 0;
        while (pin !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task plen;
        n = 0;
        while (pin === 1'b1) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task pulse_chk(input string s);
        waitp(20);
        plen;
        chk(s, 16'h0010, 16'(n));
    endtask
    task t_off;
        wr(twrg_pkg::ADDR_CTRL, 8'h02);
        @(posedge clk);
        mode <= 1'b0;
        ci <= 4'h3;
        sact <= 1'b1;
        waitp(30);
        chk("off quiet", 16'h001e, 16'(n));
        rd(twrg_pkg::ADDR_STAT);
        chk("off flags", 16'h0000, 16'(rv));
        @(posedge clk);
        mode <= 1'b1;
        sact <= 1'b0;
        waitp(8);
    endtask
    task t_awake;
        wr(twrg_pkg::ADDR_CTRL, 8'h01);
        @(posedge clk);
        mode <= 1'b0;
        waitp(20);
        @(posedge clk);
        ci <= 4'h5;
        #1 plen;
        chk("awake width", 16'h000f, 16'(n));
        chk("up forced", 16'h0000, 16'(up_o));
        rd(twrg_pkg::ADDR_STAT);
        chk("awake flags", 16'h0005, 16'(rv));
        @(posedge clk);
        mode <= 1'b1;
        sact <= 1'b1;
        pulse_chk("clocks pulse");
        chk("up free", 16'h0001, 16'(up_o));
        @(posedge clk);
        ci <= 4'h9;
        pulse_chk("code pulse");
    endtask
    task t_rss1;
        wr(twrg_pkg::ADDR_CTRL, 8'h03);
        wr(twrg_pkg::ADDR_CTRL, 8'h02);
        @(posedge clk);
        mode <= 1'b0;
        ci <= 4'h2;
        waitp(20);
        chk("rss1 quiet", 16'h0014, 16'(n));
        rd(twrg_pkg::ADDR_STAT);
        chk("rss1 flags", 16'h0005, 16'(rv & 8'h05));
    endtask
    // feed first: the count has been running since the select change in t_rss1
    task t_wdog;
        repeat (3) begin
            wr(twrg_pkg::ADDR_KEY, 8'h02);
            wr(twrg_pkg::ADDR_KEY, 8'h01);
            waitp(40);
            chk("fed", 16'h0028, 16'(n));
        end
        wr(twrg_pkg::ADDR_CTRL, 8'h01);
        wr(twrg_pkg::ADDR_CTRL, 8'h03);
        waitp(40);
        chk("select restart", 16'h0028, 16'(n));
        wr(twrg_pkg::ADDR_KEY, 8'h02);
        wr(twrg_pkg::ADDR_KEY, 8'h00);
        wr(twrg_pkg::ADDR_KEY, 8'h01);
        waitp(80);
        chk("expiry", 16'h0001, 16'(n >= 14 && n <= 26));
        rd(twrg_pkg::ADDR_STAT);
        chk("wov flag", 16'h000a, 16'(rv & 8'h0a));
        plen;
    endtask
    task t_hold;
        @(posedge clk);
        sact <= 1'b0;
        waitp(200);
        chk("held", 16'h00c8, 16'(n));
        @(posedge clk);
        sact <= 1'b1;
        waitp(100);
        chk("resumed", 16'h0001, 16'(pin));
        rd(4'h7);
        chk("unmapped", 16'h0000, 16'(rv));
        rd(twrg_pkg::ADDR_KEY);
        chk("key unreadable", 16'h0000, 16'(rv));
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            close_out;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_off;
        t_awake;
        t_rss1;
        t_wdog;
        t_hold;
        close_out;
    end
endmodule // twrg_top_tb
`default_nettype wire
